/* File: hdl/stim_one_cfg.svh */
// Constants for the stimulus-one behaviour register and its timer.
// Assumes a 40 MHz clock; included by bare name, definitions only.
`ifndef STIM_ONE_CFG_SVH
`define STIM_ONE_CFG_SVH
`define CLK_HZ            40000000
`define CYC_PER_MS        (`CLK_HZ / 1000)
`define REG_RESET         8'h00
`define REG_WRITE_MASK    8'h7f
`define BIT_TIMER_MODE    6
`define DELAY_MSB         5
`define DELAY_LSB         3
`define SRC_MSB           2
`define SRC_LSB           0
`define DELAY_MS_0        0
`define DELAY_MS_1        1
`define DELAY_MS_2        5
`define DELAY_MS_3        10
`define DELAY_MS_4        20
`define DELAY_MS_5        40
`define DELAY_MS_6        80
`define DELAY_MS_7        100
`define SRC_SUPPLY_PRE    3'h0
`define SRC_PLUS_ABOVE    3'h1
`define SRC_MINUS_ABOVE   3'h2
`define SRC_WINDOW        3'h3
`define SRC_RESERVED      3'h4
`define SRC_SUPPLY_POST   3'h7
`define WINDOW_LOW_MV     400
`endif

/* File: hdl/stim_one_pkg.sv */
// Types for the stimulus-one configuration block.
// Assumes stim_one_cfg.svh supplies the numeric constants.
package stim_one_pkg;
	typedef enum logic [1:0] {IDLE, DELAYING, HOLDING, WAIT_CLEAR} phase_type;
	typedef struct packed {
		logic       stim_one_timer_mode;
		logic [2:0] stim_one_delay_code;
		logic [2:0] stim_one_source_select;
	} cfg_type;
endpackage

/* File: hdl/stim_one_if.sv */
// Interface carrying synchronised condition levels into the core.
// Assumes one clock; driven by the synchroniser, read by the top.
`timescale 1ns/100ps
`default_nettype none
interface stim_cond_if;
	logic [4:0] level;
	modport src (output level);
	modport dst (input level);
endinterface
`default_nettype wire

/* File: hdl/stim_cond_sync.sv */
// Two-flop synchronisers for the analogue comparator and supply levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module stim_cond_sync #(
	parameter int N = 5
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Raw levels
	input  wire logic [N-1:0] raw,
	// Synchronised levels
	stim_cond_if.src          cond
);
	logic [N-1:0] meta_reg;
	logic [N-1:0] sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= raw;
			sync_reg <= meta_reg;
		end
	end
	assign cond.level = sync_reg;
endmodule
`default_nettype wire

/* File: hdl/stim_one_config.sv */
// Stimulus-one behaviour register, source select and delay/hold timer.
// Assumes comparator and supply levels arrive as async pins; one 40 MHz clock.
`timescale 1ns/100ps
`include "stim_one_cfg.svh"
`default_nettype none
// How it works
// - Bit 7 is not stored and always reads back as zero.
// - With the timer mode bit set the response is applied the moment stimulus one is seen.
// - In that mode the response is held the full time, then dropped once the stimulus is gone.
// - With the timer mode bit clear the response follows only after the programmed delay.
// - Delay codes 0 to 7 select 0, 1, 5, 10, 20, 40, 80 and 100 ms.
// - The three source bits choose which condition counts as stimulus one.
// - Source 000, the reset value, uses supply ready before the switch closes.
// - Source 001 uses the plus data line above the stimulus-one threshold.
// - Source 111 uses supply present after the switch has closed.
// - The window option compares the plus line against the threshold and a fixed 400 mV floor.
module stim_one_config
	import stim_one_pkg::*;
#(
	parameter int CLK_HZ = `CLK_HZ
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Asynchronous condition levels
	input  wire logic       supply_ready_pre,
	input  wire logic       supply_present_post,
	input  wire logic       plus_above_thresh,
	input  wire logic       minus_above_thresh,
	input  wire logic       plus_above_floor,
	// Response
	output logic            response,
	output logic            stim_active
);
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int CW     = $clog2(`DELAY_MS_7 * MS_CYC + 1);

	typedef struct packed {
		cfg_type       cfg;
		phase_type     phase;
		logic [CW-1:0] count;
		logic          resp;
		logic          stim_prev;
	} state_type;

	state_type state_reg, state_next;
	logic      stim;
	logic      stim_rise;
	logic [CW-1:0] load;

	stim_cond_if cond ();

	stim_cond_sync #(.N(5)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.raw   ({plus_above_floor, minus_above_thresh, plus_above_thresh,
		         supply_present_post, supply_ready_pre}),
		.cond  (cond)
	);

	// Delay code to cycle count
	function automatic logic [CW-1:0] delay_cycles(input logic [2:0] code);
		int ms;
		case (code)
			3'h0:    ms = `DELAY_MS_0;
			3'h1:    ms = `DELAY_MS_1;
			3'h2:    ms = `DELAY_MS_2;
			3'h3:    ms = `DELAY_MS_3;
			3'h4:    ms = `DELAY_MS_4;
			3'h5:    ms = `DELAY_MS_5;
			3'h6:    ms = `DELAY_MS_6;
			default: ms = `DELAY_MS_7;
		endcase
		return CW'(ms * MS_CYC);
	endfunction

	// Source selection; window floor is a fixed 400 mV comparator on the plus line
	always_comb begin
		case (state_reg.cfg.stim_one_source_select)
			`SRC_SUPPLY_PRE:  stim = cond.level[0];
			`SRC_PLUS_ABOVE:  stim = cond.level[2];
			`SRC_MINUS_ABOVE: stim = cond.level[3];
			`SRC_WINDOW:      stim = !cond.level[2] && cond.level[4];
			`SRC_SUPPLY_POST: stim = cond.level[1];
			`SRC_RESERVED:    stim = 1'b0;
			default:          stim = 1'b0;
		endcase
	end

	// Only a rising stimulus starts the timer, never a level that merely stays present
	assign stim_rise = stim && !state_reg.stim_prev;
	assign load      = delay_cycles(state_reg.cfg.stim_one_delay_code);

	// Next-state logic: register write, then the timer sequence
	always_comb begin
		state_next           = state_reg;
		state_next.stim_prev = stim;
		if (reg_wr) begin
			state_next.cfg = cfg_type'(reg_wdata[`BIT_TIMER_MODE:`SRC_LSB] & 7'(`REG_WRITE_MASK));
		end
		case (state_reg.phase)
			IDLE: begin
				if (stim_rise) begin
					if (state_reg.cfg.stim_one_timer_mode) begin
						state_next.resp  = 1'b1;
						state_next.count = load;
						state_next.phase = (load == '0) ? WAIT_CLEAR : HOLDING;
					end else if (load == '0) begin
						state_next.resp  = 1'b1;
						state_next.phase = WAIT_CLEAR;
					end else begin
						state_next.count = load;
						state_next.phase = DELAYING;
					end
				end
			end
			DELAYING: begin
				if (state_reg.count == CW'(1)) begin
					state_next.resp  = 1'b1;
					state_next.phase = WAIT_CLEAR;
				end
				state_next.count = state_reg.count - CW'(1);
			end
			HOLDING: begin
				state_next.count = state_reg.count - CW'(1);
				if (state_reg.count == CW'(1)) begin
					state_next.phase = WAIT_CLEAR;
				end
			end
			WAIT_CLEAR: begin
				// Response stays until the stimulus goes away; waiting here stops
				// a stimulus that stays present from restarting the timer
				if (!stim) begin
					state_next.resp  = 1'b0;
					state_next.phase = IDLE;
				end
			end
			default: state_next.phase = IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '{cfg: cfg_type'(7'(`REG_RESET)), phase: IDLE,
			               count: '0, resp: 1'b0, stim_prev: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs; top bit is not stored
	assign reg_rdata   = {1'b0, state_reg.cfg};
	assign response    = state_reg.resp;
	assign stim_active = state_reg.stim_prev;

	// Checks
	unused_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
		reg_rdata[7] == 1'b0) else $error("bit 7 read nonzero");
	immediate_resp_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == IDLE && stim_rise && state_reg.cfg.stim_one_timer_mode)
		|=> response) else $error("hold mode response late");
	hold_full_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == HOLDING) |-> response) else $error("response dropped early");
	delay_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == DELAYING) |-> !response) else $error("response before delay");
	delay_end_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == DELAYING && state_reg.count == CW'(1)) |=> response)
		else $error("response missing after delay");
	zero_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == IDLE && stim_rise && load == '0) |=> response)
		else $error("zero delay not immediate");
	src_pre_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.cfg.stim_one_source_select == `SRC_SUPPLY_PRE) |-> stim == cond.level[0])
		else $error("source 000 wrong");
	src_plus_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.cfg.stim_one_source_select == `SRC_PLUS_ABOVE) |-> stim == cond.level[2])
		else $error("source 001 wrong");
	src_post_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.cfg.stim_one_source_select == `SRC_SUPPLY_POST) |-> stim == cond.level[1])
		else $error("source 111 wrong");
	src_window_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.cfg.stim_one_source_select == `SRC_WINDOW)
		|-> stim == (!cond.level[2] && cond.level[4])) else $error("window source wrong");
	src_unused_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(state_reg.cfg.stim_one_source_select inside {`SRC_SUPPLY_PRE, `SRC_PLUS_ABOVE,
		`SRC_MINUS_ABOVE, `SRC_WINDOW, `SRC_SUPPLY_POST}) |-> !stim)
		else $error("unused source not idle");
	release_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == WAIT_CLEAR && !stim) |=> !response)
		else $error("response not removed");
	load_5ms_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.cfg.stim_one_delay_code == 3'h2) |-> load == CW'(5 * MS_CYC))
		else $error("5 ms code wrong");

	// Timer steps as named sequences: what starts a step, then what must follow it
	sequence hold_start_s;
		state_reg.phase == IDLE && stim_rise && state_reg.cfg.stim_one_timer_mode && load != '0;
	endsequence
	sequence delay_start_s;
		state_reg.phase == IDLE && stim_rise && !state_reg.cfg.stim_one_timer_mode && load != '0;
	endsequence
	sequence hold_run_s;
		state_reg.phase == HOLDING && response && state_reg.count == $past(load);
	endsequence
	sequence delay_run_s;
		state_reg.phase == DELAYING && !response && state_reg.count == $past(load);
	endsequence
	hold_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
		hold_start_s |=> hold_run_s) else $error("hold timer not loaded");
	delay_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
		delay_start_s |=> delay_run_s) else $error("delay timer not loaded");
	hold_count_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg.phase == HOLDING && state_reg.count != CW'(1))
		|=> (state_reg.phase == HOLDING && state_reg.count == $past(state_reg.count) - CW'(1)))
		else $error("hold timer skipped");
endmodule
`default_nettype wire

/* File: dv/portable_dev_model.sv */
// Model of the attached portable device presenting condition levels.
// Assumes the bench changes the wanted levels at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module portable_dev_model (
	// Clock
	input  wire logic       clk,
	// Levels the scenario asks for
	input  wire logic [4:0] want,
	// Levels seen at the block's condition pins
	output logic      [4:0] levels
);
	logic [4:0] staged;

	// Take the wish at the rising edge, show it at the next falling edge: the
	// bench's own falling-edge change of want can then never race the pins
	always @(posedge clk) begin
		staged <= want;
	end
	always @(negedge clk) begin
		levels <= staged;
	end
endmodule
`default_nettype wire

/* File: dv/charger_stimulus_one_config_tb_top.sv */
// Self-checking bench for the stimulus-one behaviour register and timer.
// Assumes CLK_HZ of 4000, so one millisecond lasts four clock cycles.
`timescale 1ns/100ps
`default_nettype none
module charger_stimulus_one_config_tb_top;
	logic       clk;
	logic       rst_b;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [4:0] want;
	logic [4:0] levels;
	logic       response;
	logic       stim_active;
	int         n_mismatch = 0;
	int         cmp_count = 0;
	int         c;
	// Level order: pre, post, plus above, minus above, plus above floor
	stim_one_config #(.CLK_HZ(4000)) stim_one_config_i (.clk(clk), .rst_b(rst_b),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.supply_ready_pre(levels[0]), .supply_present_post(levels[1]),
		.plus_above_thresh(levels[2]), .minus_above_thresh(levels[3]),
		.plus_above_floor(levels[4]), .response(response), .stim_active(stim_active));
	portable_dev_model portable_dev_model_i (.clk(clk), .want(want), .levels(levels));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	// Counts falling edges until the response rises, bounded
	task automatic lat(output int n);
		n = 0;
		while (response !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Counts falling edges while the response stays up, bounded
	task automatic held(output int n);
		n = 0;
		while (response === 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic idle;
		want = 5'h00;
		repeat (12) @(negedge clk);
	endtask
	task automatic t_reg;
		chk("rdata reset", 16'h0000, {8'h00, reg_rdata});
		wr(8'hff);
		chk("rdata bit7", 16'h007f, {8'h00, reg_rdata});
	endtask
	// Sources 000, 001, 010, 011 and 111 with a wrong condition, then with their own; 101 and 110 only with a wrong one; 100 is never written
	task automatic t_src;
		logic [2:0] s [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6};
		logic [4:0] ok [7] = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h02, 5'h00, 5'h00};
		logic [4:0] bad [7] = '{5'h02, 5'h08, 5'h04, 5'h14, 5'h01, 5'h1f, 5'h1f};
		for (int i = 0; i < 7; i++) begin
			wr({5'h00, s[i]});
			idle();
			want = bad[i];
			repeat (20) @(negedge clk);
			chk("wrong source", 16'h0000, {15'h0000, response});
			chk("stim idle", 16'h0000, {15'h0000, stim_active});
			idle();
			if (i < 5) begin
				want = ok[i];
				lat(c);
				chk("source hit", 16'h0001, {15'h0000, response});
				chk("stim seen", 16'h0001, {15'h0000, stim_active});
				idle();
			end
		end
	endtask
	// Delay mode: response comes the programmed time after detection
	task automatic t_delay;
		int ms [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
		for (int k = 0; k < 8; k++) begin
			wr({2'b00, k[2:0], 3'h1});
			idle();
			want = 5'h04;
			lat(c);
			c = c - ms[k] * 4;
			chk("delay latency", 16'h0001, {15'h0000, c >= 3 && c <= 5});
			idle();
		end
	endtask
	// Hold mode: at once, for the full time, then until the stimulus clears
	task automatic t_hold;
		wr(8'h51);
		idle();
		want = 5'h04;
		lat(c);
		chk("hold latency", 16'h0001, {15'h0000, c >= 3 && c <= 5});
		want = 5'h00;
		held(c);
		chk("hold length", 16'h0001, {15'h0000, c >= 19 && c <= 22});
		idle();
		want = 5'h04;
		lat(c);
		repeat (40) @(negedge clk);
		chk("hold kept", 16'h0001, {15'h0000, response});
		want = 5'h00;
		repeat (6) @(negedge clk);
		chk("hold released", 16'h0000, {15'h0000, response});
		wr(8'h41);
		want = 5'h04;
		lat(c);
		chk("hold zero latency", 16'h0004, 16'(c));
		want = 5'h00;
		held(c);
		chk("hold zero length", 16'h0004, 16'(c));
		idle();
	endtask
	// Reset in mid-hold: response and settings drop; the plus line alone then does nothing
	task automatic t_reset;
		wr(8'h51);
		want = 5'h04;
		lat(c);
		rst_b = 1'b0;
		@(negedge clk);
		chk("reset response", 16'h0000, {15'h0000, response});
		chk("reset rdata", 16'h0000, {8'h00, reg_rdata});
		rst_b = 1'b1;
		repeat (12) @(negedge clk);
		chk("default source", 16'h0000, {15'h0000, response});
		idle();
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Hang guard: the sequence needs about 1800 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		want = 5'h00;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		t_reg();
		t_src();
		t_delay();
		t_hold();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
